// ---- hdl/cmfb_fifo.sv ----
// cmfb_fifo: small synchronous fifo, registered read data
// assumes: single clock, asynchronous active low reset
`timescale 1ns/100ps
module cmfb_fifo #(
    parameter int unsigned W = 32,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    cmfb_fifo_if.fifo s
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic [W-1:0] dout_q, dout_d;
    logic ov_q, ov_d;
    logic rdy_q, rdy_d;
    logic push, pop, load;

    // -----------------------------------------------------------------
    // pointers and output register
    // -----------------------------------------------------------------
    always_comb begin
        pop = ov_q && s.out_ready;
        load = (cnt_q != '0) && (!ov_q || pop);
        push = s.in_valid && rdy_q;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = load ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        dout_d = load ? mem_q[rp_q] : dout_q;
        ov_d = load ? 1'b1 : (pop ? 1'b0 : ov_q);
        // registered so that the ready seen outside comes from a flop
        rdy_d = (cnt_d != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            dout_q <= '0;
            ov_q <= 1'b0;
            rdy_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            ov_q <= ov_d;
            rdy_q <= rdy_d;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= s.in_data;
        end
    end

    assign s.in_ready = rdy_q;
    assign s.out_valid = ov_q;
    assign s.out_data = dout_q;
endmodule // cmfb_fifo

// ---- hdl/cmfb_fifo_if.sv ----
// cmfb_fifo_if: valid/ready stream between the fill logic and its fifo
// assumes: one clock domain, transfer when valid and ready are both high
`timescale 1ns/100ps
interface cmfb_fifo_if #(parameter int unsigned W = 32);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
    modport user (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface // cmfb_fifo_if

// ---- hdl/cmfb_fill.sv ----
// cmfb_fill: cache miss fill with fetch bypass and wraparound load buffer
// assumes: hit/miss decided outside; memory burst port same clock domain
//
// Behaviour
// [RULE1] a processor miss starts a cycle that fetches the block and feeds cache and processor.
// [RULE2] the bypass buffer takes the requested word as soon as memory returns it.
// [RULE3] the processor gets the missed word from the bypass and may continue at once.
// [RULE4] all block words gather in the wraparound buffer and the array is written once complete.
// [RULE5] a later request into the block stalls until the update, or is served from the buffer.
// [RULE6] one address is issued per 16-byte block, not one per 4-byte word.
// [RULE7] a block is 16 bytes, four consecutive words after one start address.
// [RULE8] the nibble memory takes one address and shifts four words out on strobes.
// [RULE9] the nibble memory precharges once, after all four words.
// [RULE10] standard memory needs one address and precharge per access, handled by its controller.
// [RULE11] page or static column memory gets column addresses from its controller.
// [RULE12] gated row precharge may end the row strobe early, handled by the controller.
// [RULE13] the burst starts at the missed word and wraps to the block start.
`timescale 1ns/100ps
module cmfb_fill #(
    parameter int unsigned W = cmfb_pkg::WORD_W,
    parameter int unsigned AW = cmfb_pkg::ADDR_W,
    parameter int unsigned DEPTH = cmfb_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cpu_miss,
    input wire logic [AW-1:0] cpu_addr,
    input wire logic cpu_req,
    input wire logic [AW-1:0] cpu_req_addr,
    output logic cpu_rdata_valid,
    output logic [W-1:0] cpu_rdata,
    output logic cpu_stall,
    output logic mem_addr_valid,
    output logic [AW-1:0] mem_addr,
    input wire logic mem_addr_ready,
    input wire logic mem_data_valid,
    input wire logic [W-1:0] mem_data,
    output logic mem_data_ready,
    output logic cache_wr,
    output logic [AW-1:0] cache_wr_addr,
    output logic [W*cmfb_pkg::BLOCK_WORDS-1:0] cache_wr_block,
    output logic busy
);
    localparam int unsigned NW = cmfb_pkg::BLOCK_WORDS;
    localparam int unsigned OW = cmfb_pkg::OFS_W;

    cmfb_fifo_if #(.W(W)) fq ();
    cmfb_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .s(fq)
    );

    cmfb_pkg::cmfb_state_t st_q, st_d;
    logic [AW-OW-1:0] blk_q, blk_d;
    logic [OW-1:0] crit_q, crit_d, ofs_q, ofs_d;
    logic [NW-1:0] have_q, have_d;
    logic [W-1:0] wbuf_q [NW];
    logic [W-1:0] wbuf_d [NW];
    logic [W-1:0] byp_q, byp_d;
    logic rv_q, rv_d, stall_q, stall_d, mav_q, mav_d, cw_q, cw_d;
    logic busy_q, busy_d;
    logic [W-1:0] rd_q, rd_d;
    logic [AW-1:0] ma_q, ma_d;
    logic [AW-1:0] cwa_q, cwa_d;
    logic [W*NW-1:0] cwb_q, cwb_d;
    logic take, same_blk;
    logic [OW-1:0] req_ofs;

    // memory words enter the fifo; the fill logic drains it one per cycle
    assign fq.in_valid = mem_data_valid;
    assign fq.in_data = mem_data;
    assign fq.out_ready = (st_q == cmfb_pkg::CMFB_FILL);
    assign take = fq.out_valid && fq.out_ready;
    assign same_blk = (cpu_req_addr[AW-1:OW] == blk_q);
    assign req_ofs = cpu_req_addr[OW-1:0];

    // -----------------------------------------------------------------
    // miss sequencer
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        blk_d = blk_q;
        crit_d = crit_q;
        ofs_d = ofs_q;
        have_d = have_q;
        wbuf_d = wbuf_q;
        byp_d = byp_q;
        rv_d = 1'b0;
        rd_d = rd_q;
        stall_d = 1'b0;
        mav_d = mav_q;
        ma_d = ma_q;
        cw_d = 1'b0;
        cwa_d = cwa_q;
        cwb_d = cwb_q;
        case (st_q)
            cmfb_pkg::CMFB_IDLE: begin
                // the array write cycle still counts as busy, so a miss waits for it
                if (cpu_miss && !cw_q) begin // [RULE1]
                    blk_d = cpu_addr[AW-1:OW];
                    crit_d = cpu_addr[OW-1:0];
                    ofs_d = cpu_addr[OW-1:0]; // [RULE13]
                    have_d = '0;
                    mav_d = 1'b1;
                    ma_d = cpu_addr; // critical word first, one address [RULE6]
                    stall_d = 1'b1;
                    st_d = cmfb_pkg::CMFB_ADDR;
                end
            end
            cmfb_pkg::CMFB_ADDR: begin
                stall_d = 1'b1;
                if (mem_addr_ready) begin
                    mav_d = 1'b0; // address drops once taken; strobe timing is the controller's [RULE12]
                    st_d = cmfb_pkg::CMFB_FILL;
                end
            end
            cmfb_pkg::CMFB_FILL: begin
                stall_d = stall_q;
                if (take) begin
                    wbuf_d[ofs_q] = fq.out_data; // [RULE4]
                    have_d[ofs_q] = 1'b1;
                    ofs_d = ofs_q + cmfb_pkg::OFS_ONE; // wraps in block [RULE7] [RULE13]
                    if (ofs_q == crit_q) begin
                        byp_d = fq.out_data; // [RULE2]
                        rv_d = 1'b1; // [RULE3]
                        rd_d = fq.out_data;
                        stall_d = 1'b0;
                    end
                    if (ofs_d == crit_q) begin
                        st_d = cmfb_pkg::CMFB_WRITE;
                    end
                end
                // later word of this block: serve from buffer or hold [RULE5]
                if (cpu_req && same_blk && !(take && ofs_q == crit_q)) begin
                    if (have_q[req_ofs]) begin
                        rv_d = 1'b1;
                        rd_d = (req_ofs == crit_q) ? byp_q : wbuf_q[req_ofs]; // [RULE2]
                        stall_d = 1'b0;
                    end else begin
                        stall_d = 1'b1;
                    end
                end
            end
            cmfb_pkg::CMFB_WRITE: begin
                cw_d = 1'b1; // one array write for the whole block [RULE4]
                cwa_d = {blk_q, {OW{1'b0}}};
                for (int i = 0; i < NW; i++) begin
                    cwb_d[i*W +: W] = wbuf_q[i];
                end
                // last word of the wrap lands here; serve it rather than stall [RULE5]
                if (cpu_req && same_blk) begin
                    rv_d = 1'b1;
                    rd_d = wbuf_q[req_ofs];
                end
                st_d = cmfb_pkg::CMFB_IDLE;
            end
            default: begin
                st_d = cmfb_pkg::CMFB_IDLE;
            end
        endcase
        busy_d = (st_d != cmfb_pkg::CMFB_IDLE) || cw_d;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= cmfb_pkg::CMFB_IDLE;
            blk_q <= '0;
            crit_q <= '0;
            ofs_q <= '0;
            have_q <= '0;
            byp_q <= '0;
            rv_q <= 1'b0;
            rd_q <= '0;
            stall_q <= 1'b0;
            mav_q <= 1'b0;
            ma_q <= '0;
            cw_q <= 1'b0;
            cwa_q <= '0;
            cwb_q <= '0;
            busy_q <= 1'b0;
            for (int i = 0; i < NW; i++) begin
                wbuf_q[i] <= '0;
            end
        end else begin
            st_q <= st_d;
            blk_q <= blk_d;
            crit_q <= crit_d;
            ofs_q <= ofs_d;
            have_q <= have_d;
            byp_q <= byp_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            stall_q <= stall_d;
            mav_q <= mav_d;
            ma_q <= ma_d;
            cw_q <= cw_d;
            cwa_q <= cwa_d;
            cwb_q <= cwb_d;
            busy_q <= busy_d;
            for (int i = 0; i < NW; i++) begin
                wbuf_q[i] <= wbuf_d[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs, all registered
    // -----------------------------------------------------------------
    assign cpu_rdata_valid = rv_q;
    assign cpu_rdata = rd_q;
    assign cpu_stall = stall_q;
    assign mem_addr_valid = mav_q;
    assign mem_addr = ma_q;
    // fifo full pushes back on the memory burst
    assign mem_data_ready = fq.in_ready;
    assign cache_wr = cw_q;
    assign cache_wr_addr = cwa_q;
    assign cache_wr_block = cwb_q;
    assign busy = busy_q;
endmodule // cmfb_fill

// ---- hdl/cmfb_pkg.sv ----
// cmfb_pkg: shared constants and types for the miss fill with bypass
// assumes: word addressed processor, 32-bit words, four-word blocks
package cmfb_pkg;
    // -----------------------------------------------------------------
    // geometry
    // -----------------------------------------------------------------
    localparam int unsigned WORD_W = 32;
    localparam int unsigned BLOCK_BYTES = 16;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
    localparam int unsigned OFS_W = 2;
    localparam int unsigned ADDR_W = 30;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [OFS_W-1:0] OFS_LAST = 2'h3;
    localparam logic [OFS_W-1:0] OFS_ONE = 2'h1;
    // -----------------------------------------------------------------
    // fill sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMFB_IDLE,
        CMFB_ADDR,
        CMFB_FILL,
        CMFB_WRITE
    } cmfb_state_t;
endpackage

// ---- verif/cmfb_fill_assertions.sv ----
// cmfb_fill_assertions: port checks on the miss fill block
// assumes: bound into cmfb_fill, one clock, reset low
`timescale 1ns/100ps
module cmfb_fill_chk #(
    parameter int unsigned AW = 30
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cpu_miss,
    input wire logic [AW-1:0] cpu_addr,
    input wire logic cpu_rdata_valid,
    input wire logic cpu_stall,
    input wire logic mem_addr_valid,
    input wire logic [AW-1:0] mem_addr,
    input wire logic mem_addr_ready,
    input wire logic mem_data_valid,
    input wire logic mem_data_ready,
    input wire logic cache_wr,
    input wire logic [AW-1:0] cache_wr_addr,
    input wire logic busy
);
    logic [2:0] beats_q;
    logic [2:0] beats_d;
    logic [2:0] addrs_q;
    logic [2:0] addrs_d;
    logic got_q;
    logic got_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // counts clear while idle, so each fill is judged alone
    always_comb begin
        beats_d = busy ? beats_q + 3'(mem_data_valid && mem_data_ready) : 3'h0;
        addrs_d = busy ? addrs_q + 3'(mem_addr_valid && mem_addr_ready) : 3'h0;
        got_d = busy && (got_q || cpu_rdata_valid);
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            beats_q <= 3'h0;
            addrs_q <= 3'h0;
            got_q <= 1'b0;
        end else begin
            beats_q <= beats_d;
            addrs_q <= addrs_d;
            got_q <= got_d;
        end
    end
    sequence miss_s; !busy && cpu_miss; endsequence
    sequence issue_s; mem_addr_valid && cpu_stall && busy; endsequence
    miss_addr_a: assert property (
        miss_s |=> issue_s ##0 mem_addr == $past(cpu_addr))
        else $error("no burst address for miss");
    addr_hold_a: assert property (
        mem_addr_valid && !mem_addr_ready |=> mem_addr_valid && $stable(mem_addr))
        else $error("burst address dropped");
    one_addr_a: assert property (addrs_q < 3'h2)
        else $error("second address in one fill");
    full_block_a: assert property (cache_wr |-> beats_q == 3'h4)
        else $error("array written without four words");
    bypass_first_a: assert property (cache_wr |-> got_q)
        else $error("array written before missed word given");
    wr_pulse_a: assert property (cache_wr |=> !cache_wr && !busy)
        else $error("array write not single");
    wr_base_a: assert property (cache_wr |-> cache_wr_addr[1:0] == 2'h0)
        else $error("array write not block aligned");
    stall_end_a: assert property ($fell(cpu_stall) |-> cpu_rdata_valid)
        else $error("stall ended without data");
    word_bound_a: assert property ($rose(mem_addr_valid) |-> ##[5:60] cpu_rdata_valid)
        else $error("missed word late");
endmodule // cmfb_fill_chk
bind cmfb_fill cmfb_fill_chk #(.AW(AW)) u_chk (.clk, .resetn, .cpu_miss, .cpu_addr,
    .cpu_rdata_valid, .cpu_stall, .mem_addr_valid, .mem_addr, .mem_addr_ready,
    .mem_data_valid, .mem_data_ready, .cache_wr, .cache_wr_addr, .busy);

// ---- verif/cmfb_mem_model.sv ----
// cmfb_mem_model: burst memory on the fill port
// assumes: same clock, one address returns four wrapped words
`timescale 1ns/100ps
module cmfb_mem_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic mem_addr_valid,
    input wire logic [cmfb_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_addr_ready,
    output logic mem_data_valid,
    output logic [cmfb_pkg::WORD_W-1:0] mem_data,
    input wire logic mem_data_ready
);
    logic [cmfb_pkg::ADDR_W-1:0] a_q;
    logic [31:0] last_q;
    logic [2:0] n_q;
    logic gap_q;
    logic [1:0] ofs;
    // slow mode answers every other cycle only
    assign mem_addr_ready = n_q == 3'h0 && (!slow || gap_q);
    assign ofs = a_q[1:0] + 2'(3'h4 - n_q);
    // idle bus shows the inverse, not a stale word
    assign mem_data = mem_data_valid ? {2'h2, a_q[29:2], ofs} : ~last_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_q <= '0;
            last_q <= '0;
            n_q <= 3'h0;
            gap_q <= 1'b0;
            mem_data_valid <= 1'b0;
        end else begin
            gap_q <= !gap_q;
            if (mem_addr_valid && mem_addr_ready) begin
                // one address per burst; per-access or column timing stays inside
                a_q <= mem_addr;
                n_q <= 3'h5;
            end else if (mem_data_valid && mem_data_ready) begin
                // four beats, no precharge between them
                mem_data_valid <= n_q > 3'h1 && !slow;
                n_q <= n_q - 3'h1;
                last_q <= mem_data;
            end else if (n_q == 3'h5) begin
                n_q <= 3'h4;
            end else if (n_q != 3'h0 && (!slow || gap_q)) begin
                mem_data_valid <= 1'b1;
            end
        end
    end
endmodule // cmfb_mem_model

// ---- verif/test_cache_miss_fill_with_bypass.sv ----
// test_cache_miss_fill_with_bypass: self-checking bench for cmfb_fill
// assumes: cmfb_mem_model on the memory port, bench plays the processor
`timescale 1ns/100ps
module test_cache_miss_fill_with_bypass;
    typedef struct packed {
        logic [29:0] a;
        logic s;
        logic [31:0] w;
        logic [29:0] b;
    } cmfb_row_t;
    logic clk, resetn, cpu_miss, cpu_req, slow, idle;
    logic cpu_rdata_valid, cpu_stall, mem_addr_valid, mem_addr_ready;
    logic mem_data_valid, mem_data_ready, cache_wr, busy;
    logic [29:0] cpu_addr, cpu_req_addr, mem_addr, cache_wr_addr;
    logic [31:0] cpu_rdata, mem_data;
    logic [127:0] cache_wr_block;
    int n_mismatch = 0;
    int n_checks = 0;
    // missed address, slow memory, critical word, block base
    cmfb_row_t rows [4] = '{
        {30'h0001_2340, 1'b0, 32'h8001_2340, 30'h0001_2340},
        {30'h0001_2345, 1'b1, 32'h8001_2345, 30'h0001_2344},
        {30'h0002_002a, 1'b0, 32'h8002_002a, 30'h0002_0028},
        {30'h3fff_ffff, 1'b1, 32'hbfff_ffff, 30'h3fff_fffc}};
    always_comb idle = !busy;
    cmfb_fill uut (.clk, .resetn, .cpu_miss, .cpu_addr, .cpu_req, .cpu_req_addr,
        .cpu_rdata_valid, .cpu_rdata, .cpu_stall, .mem_addr_valid, .mem_addr,
        .mem_addr_ready, .mem_data_valid, .mem_data, .mem_data_ready, .cache_wr,
        .cache_wr_addr, .cache_wr_block, .busy);
    cmfb_mem_model mem (.clk, .resetn, .slow, .mem_addr_valid, .mem_addr,
        .mem_addr_ready, .mem_data_valid, .mem_data, .mem_data_ready);
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 60 && s !== 1'b1; i++) @(negedge clk);
        if (s !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic chk_idle();
        chk(busy, 1'b0);
        chk(cpu_stall, 1'b0);
        chk(cache_wr, 1'b0);
        chk(mem_addr_valid, 1'b0);
        chk(mem_data_ready, 1'b1);
    endtask
    task automatic fill(input cmfb_row_t r);
        logic [127:0] blk;
        for (int k = 0; k < 4; k++) blk[32*k+:32] = {2'h2, r.a[29:2], 2'(k)};
        slow = r.s;
        cpu_miss = 1'b1;
        cpu_addr = r.a;
        @(negedge clk);
        cpu_miss = 1'b0;
        chk(cpu_stall, 1'b1);
        wait_hi(cpu_rdata_valid);
        chk(cpu_rdata, r.w);
        chk(cpu_stall, 1'b0);
        wait_hi(cache_wr);
        chk(cache_wr_addr, r.b);
        chk(cache_wr_block, blk);
        wait_hi(idle);
    endtask
    initial begin
        {cpu_miss, cpu_req, slow, resetn} = 4'h0;
        cpu_addr = '0;
        cpu_req_addr = '0;
        repeat (3) @(negedge clk);
        chk_idle();
        resetn = 1'b1;
        foreach (rows[i]) fill(rows[i]);
        // a miss held high while busy must not start a second fill
        slow = 1'b1;
        cpu_miss = 1'b1;
        cpu_addr = 30'h0000_0105;
        @(negedge clk);
        cpu_addr = 30'h0000_0200;
        repeat (2) @(negedge clk);
        cpu_miss = 1'b0;
        cpu_req = 1'b1;
        cpu_req_addr = 30'h0000_0107;
        wait_hi(cpu_rdata_valid);
        chk(cpu_rdata, 32'h8000_0105);
        @(negedge clk);
        wait_hi(cpu_rdata_valid);
        chk(cpu_rdata, 32'h8000_0107);
        cpu_req = 1'b0;
        wait_hi(cache_wr);
        chk(cache_wr_addr, 30'h0000_0104);
        wait_hi(idle);
        // last word of the wrap asked for: served as the block completes
        cpu_miss = 1'b1;
        cpu_addr = 30'h0000_0106;
        @(negedge clk);
        cpu_miss = 1'b0;
        wait_hi(cpu_rdata_valid);
        chk(cpu_rdata, 32'h8000_0106);
        cpu_req = 1'b1;
        cpu_req_addr = 30'h0000_0105;
        @(negedge clk);
        chk(cpu_stall, 1'b1);
        wait_hi(cpu_rdata_valid);
        chk(cpu_rdata, 32'h8000_0105);
        cpu_req = 1'b0;
        wait_hi(idle);
        // reset in mid-fill; the four-word burst cannot fill the fifo
        cpu_miss = 1'b1;
        cpu_addr = 30'h0000_0032;
        @(negedge clk);
        cpu_miss = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        chk_idle();
        resetn = 1'b1;
        fill(rows[2]);
        give_verdict();
    end
endmodule // test_cache_miss_fill_with_bypass
